// ---- shared/codec_params.svh ----
// Constants for the delta-sigma to companded code converter
`ifndef CODEC_PARAMS_SVH
`define CODEC_PARAMS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CDC_FRAME_US 125
`define CDC_MAIN_KHZ 2048
`define CDC_FRAME_TICKS (`CDC_FRAME_US * `CDC_MAIN_KHZ / 1000)
`define CDC_BIT_TICKS (`CDC_FRAME_TICKS / 8)
`define CDC_BIT_CENTRE 5'h10
`define CDC_LAST_TICK 8'hFF

// ----------------------------------------
// Code layout and reset values
// ----------------------------------------
`define CDC_SIGN_BIT 7
`define CDC_INV_MASK 8'h55
`define CDC_IDLE_CODE 8'hFF
`define CDC_LIN_OFFSET 14'h1000
`define CDC_MU_CLAMP 13'h1FDE
`define CDC_MU_BIAS 13'h0021
`define CDC_MOD_FULL 16'sh2000

`endif

// ---- shared/codec_pkg.sv ----
// Types shared by the code converter
package codec_pkg;
    typedef logic [7:0] code_type;
    typedef logic signed [13:0] lin_type;
    typedef enum logic [1:0]
    {
        TIMING_EXT = 2'b01,
        TIMING_INT = 2'b10
    } timing_type;
endpackage

// ---- core/pcm_delta_sigma_code_converter.sv ----
// Encoder and decoder halves of the delta-sigma / companded code converter
`timescale 1ns/1ps
`default_nettype none
`include "codec_params.svh"

module pcm_delta_sigma_code_converter
(
    // System
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Static selects
    input wire logic interface_timing_select_in,
    input wire logic digit_inversion_select_in,
    input wire logic law_select_in,
    input wire logic decoder_delay_sel_msb_in,
    input wire logic decoder_delay_sel_lsb_in,
    // Encoder side
    input wire logic encoder_main_clock_in,
    input wire logic encoder_shift_clock_in,
    input wire logic encoder_frame_pulse_in,
    input wire logic pulse_density_in,
    input wire logic signalling_in,
    output logic serial_code_out,
    output logic noise_shaping_out,
    output logic sign_bit_out,
    // Decoder side
    input wire logic decoder_main_clock_in,
    input wire logic decoder_shift_clock_in,
    input wire logic decoder_frame_pulse_in,
    input wire logic serial_code_in,
    input wire logic modulator_test_reset_in,
    output logic signalling_out,
    output logic pulse_density_out
);
    import codec_pkg::*;

    // ----------------------------------------
    // Companding functions
    // ----------------------------------------
    function automatic code_type compress(input lin_type lin, input logic mu);
        logic neg;
        logic [12:0] mag;
        logic [12:0] m;
        logic [2:0] seg;
        logic [3:0] mant;
        neg = lin[13];
        mag = neg ? 13'(-lin) : lin[12:0];
        seg = 3'h0;
        if (mu)
        begin
            m = (mag > `CDC_MU_CLAMP) ? 13'h1FFF : 13'(mag + `CDC_MU_BIAS);
            for (int i = 0; i < 8; i++)
                if (m[i + 5])
                    seg = 3'(i);
            mant = 4'(m >> (seg + 3'h1));
            compress = ~{neg, seg, mant};
        end
        else
        begin
            // A-law works on 12-bit magnitude
            m = {1'b0, mag[12:1]};
            for (int i = 1; i < 8; i++)
                if (m[i + 4])
                    seg = 3'(i);
            mant = (seg == 3'h0) ? 4'(m >> 1) : 4'(m >> seg);
            compress = {~neg, seg, mant};
        end
    endfunction

    function automatic lin_type expand(input code_type code, input logic mu);
        code_type c;
        logic neg;
        logic [13:0] t;
        c = mu ? ~code : code;
        neg = mu ? c[7] : ~c[7];
        if (mu)
            t = 14'(({10'h0, c[3:0]} << 1) + 14'h0021) << c[6:4];
        else if (c[6:4] == 3'h0)
            t = {9'h0, c[3:0], 1'b1};
        else
            t = {8'h0, 1'b1, c[3:0], 1'b1} << (c[6:4] - 3'h1);
        if (mu)
            t = t - 14'h0021;
        else
            t = t << 1;
        expand = neg ? lin_type'(-t) : lin_type'(t);
    endfunction

    // ----------------------------------------
    // Common
    // ----------------------------------------
    timing_type timing;
    logic [1:0] dec_delay;
    assign timing = interface_timing_select_in ? TIMING_INT : TIMING_EXT;
    assign dec_delay = {decoder_delay_sel_msb_in, decoder_delay_sel_lsb_in};

    // ----------------------------------------
    // Encoder timing
    // ----------------------------------------
    logic enc_clk_q_r;
    logic enc_fp_q_r;
    logic sce_q_r;
    logic [7:0] enc_cnt_r;
    logic [7:0] enc_cnt_nxt;
    logic enc_tick;
    logic frame_start;
    logic sce_rise;

    // Each half's frame counter steps only on its own main clock edge
    assign enc_tick = encoder_main_clock_in & ~enc_clk_q_r;
    assign sce_rise = encoder_shift_clock_in & ~sce_q_r;
    // The counter flywheels if a frame pulse goes missing
    assign frame_start = enc_tick & ((encoder_frame_pulse_in & ~enc_fp_q_r)
        | (enc_cnt_r == `CDC_LAST_TICK));
    assign enc_cnt_nxt = frame_start ? 8'h00 : 8'(enc_cnt_r + 8'h01);

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            enc_clk_q_r <= 1'b0;
            sce_q_r <= 1'b0;
            enc_fp_q_r <= 1'b0;
            enc_cnt_r <= 8'h00;
        end
        else
        begin
            enc_clk_q_r <= encoder_main_clock_in;
            sce_q_r <= encoder_shift_clock_in;
            if (enc_tick)
            begin
                enc_fp_q_r <= encoder_frame_pulse_in;
                enc_cnt_r <= enc_cnt_nxt;
            end
        end
    end

    // ----------------------------------------
    // Encoder conversion
    // ----------------------------------------
    logic [8:0] ones_r;
    code_type enc_raw_r;
    code_type enc_word_r;
    code_type raw_new;
    code_type word_new;
    lin_type enc_lin;

    assign enc_lin = lin_type'({ones_r, 5'h00} - `CDC_LIN_OFFSET);
    assign raw_new = compress(enc_lin, law_select_in);
    assign word_new = digit_inversion_select_in ? (raw_new ^ `CDC_INV_MASK)
        : raw_new;

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            ones_r <= 9'h000;
            enc_raw_r <= `CDC_IDLE_CODE;
            enc_word_r <= `CDC_IDLE_CODE;
        end
        else if (frame_start)
        begin
            ones_r <= {8'h00, pulse_density_in};
            enc_raw_r <= raw_new;
            enc_word_r <= word_new;
        end
        else if (enc_tick)
            ones_r <= 9'(ones_r + {8'h00, pulse_density_in});
    end

    // ----------------------------------------
    // Encoder serial output
    // ----------------------------------------
    code_type tx_sr_r;
    logic [3:0] tx_cnt_r;
    code_type word_cur;
    assign word_cur = frame_start ? word_new : enc_word_r;

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            tx_sr_r <= `CDC_IDLE_CODE;
            tx_cnt_r <= 4'h8;
        end
        else if (frame_start)
        begin
            tx_sr_r <= word_new;
            tx_cnt_r <= 4'h0;
        end
        else if (sce_rise && tx_cnt_r != 4'h8)
        begin
            tx_sr_r <= {tx_sr_r[6:0], 1'b0};
            tx_cnt_r <= 4'(tx_cnt_r + 4'h1);
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
            serial_code_out <= 1'b1;
        else if (timing == TIMING_INT)
        begin
            if (enc_tick)
                serial_code_out <= word_cur[3'(7 - enc_cnt_nxt[7:5])];
        end
        else if (sce_rise && !frame_start)
            serial_code_out <= (tx_cnt_r != 4'h8) ? tx_sr_r[7]
                : signalling_in;
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            noise_shaping_out <= 1'b0;
            sign_bit_out <= 1'b0;
        end
        else
        begin
            if (enc_tick)
                noise_shaping_out <= ~enc_cnt_nxt[7];
            sign_bit_out <= enc_raw_r[`CDC_SIGN_BIT];
        end
    end

    // ----------------------------------------
    // Decoder input
    // ----------------------------------------
    logic dec_clk_q_r;
    logic scd_q_r;
    logic [7:0] dec_cnt_r;
    code_type rx_sr_r;
    code_type dec_code_r;
    logic dec_new_r;
    logic dec_tick;
    logic scd_rise;
    logic [7:0] dec_phase;
    logic int_sample;
    logic ext_sample;
    code_type rx_shift;

    assign dec_tick = decoder_main_clock_in & ~dec_clk_q_r;
    assign scd_rise = decoder_shift_clock_in & ~scd_q_r;
    assign dec_phase = 8'(dec_cnt_r - {1'b0, dec_delay, 5'h00});
    assign int_sample = (timing == TIMING_INT) && dec_tick
        && dec_phase[4:0] == `CDC_BIT_CENTRE;
    assign ext_sample = (timing == TIMING_EXT) && scd_rise;
    assign rx_shift = {rx_sr_r[6:0], serial_code_in};

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            dec_clk_q_r <= 1'b0;
            scd_q_r <= 1'b0;
            dec_cnt_r <= 8'h00;
            rx_sr_r <= `CDC_IDLE_CODE;
            dec_code_r <= `CDC_IDLE_CODE;
            dec_new_r <= 1'b0;
        end
        else
        begin
            dec_clk_q_r <= decoder_main_clock_in;
            scd_q_r <= decoder_shift_clock_in;
            dec_new_r <= 1'b0;
            if (dec_tick)
                dec_cnt_r <= 8'(dec_cnt_r + 8'h01);
            if (int_sample || ext_sample)
                rx_sr_r <= rx_shift;
            // Phase slot 7 holds the last bit, so bit 1 lands in the top position
            if ((int_sample && dec_phase[7:5] == 3'h7)
                || (ext_sample && decoder_frame_pulse_in))
            begin
                dec_code_r <= rx_shift;
                dec_new_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
            signalling_out <= 1'b0;
        else if (ext_sample)
            signalling_out <= serial_code_in;
    end

    // ----------------------------------------
    // Decoder expansion and modulator
    // ----------------------------------------
    lin_type dec_lin_r;
    logic signed [15:0] acc_r;
    logic signed [15:0] acc_nxt;
    code_type dec_plain;

    assign dec_plain = digit_inversion_select_in ? (dec_code_r ^ `CDC_INV_MASK) : dec_code_r;
    // Feedback of full scale keeps the accumulator bounded for any legal code
    assign acc_nxt = 16'(acc_r + 16'(dec_lin_r)
        - (pulse_density_out ? `CDC_MOD_FULL : -`CDC_MOD_FULL));

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
            dec_lin_r <= 14'h0000;
        else if (dec_new_r)
            dec_lin_r <= expand(dec_plain, law_select_in);
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in || modulator_test_reset_in)
        begin
            acc_r <= 16'sh0000;
            pulse_density_out <= 1'b0;
        end
        else if (dec_tick)
        begin
            acc_r <= acc_nxt;
            pulse_density_out <= ~acc_nxt[15];
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_frame_wrap: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        frame_start |=> enc_cnt_r == 8'h00 && enc_word_r == $past(word_new))
        else $error("codeword not taken at frame start");

    a_adi_off: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        frame_start && !digit_inversion_select_in |=> enc_word_r == enc_raw_r)
        else $error("inversion applied while disabled");

    a_int_bit: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        enc_tick && timing == TIMING_INT && !frame_start && enc_cnt_r[4:0] == 5'h1F
        |=> serial_code_out == enc_word_r[3'(7 - enc_cnt_r[7:5])])
        else $error("internal serial bit wrong");

    a_sig_merge: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        timing == TIMING_EXT && sce_rise && !frame_start && tx_cnt_r == 4'h8
        |=> serial_code_out == $past(signalling_in))
        else $error("signalling bit not merged");

    a_shaping_rate: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        frame_start |=> noise_shaping_out)
        else $error("shaping wave not high at frame start");

    a_sign_track: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        frame_start |=> ##1 sign_bit_out == enc_raw_r[`CDC_SIGN_BIT])
        else $error("sign output stale");

    a_dec_delay: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        int_sample |-> dec_cnt_r[4:0] == `CDC_BIT_CENTRE
        && dec_phase[7:5] == 3'(dec_cnt_r[7:5] - {1'b0, dec_delay}))
        else $error("decoder sample phase wrong");

    a_ext_latch: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        ext_sample && decoder_frame_pulse_in |=> dec_new_r && dec_code_r == $past(rx_shift)
        ##1 dec_lin_r == expand(dec_plain, law_select_in))
        else $error("external codeword not latched");

    a_mod_reset: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        modulator_test_reset_in |=> acc_r == 16'sh0000 && !pulse_density_out)
        else $error("modulator not cleared");

endmodule // pcm_delta_sigma_code_converter
`default_nettype wire

// ---- sim/codec_far_side.sv ----
// Behavioural far side: main clocks, frame pulse and pulse-density stream
`timescale 1ns/1ps
`default_nettype none

module codec_far_side
(
    // System
    input wire logic clk_in,
    // Clocks and framing
    output logic encoder_main_clock_out = 1'b0,
    output logic decoder_main_clock_out = 1'b0,
    output logic encoder_frame_pulse_out = 1'b0,
    // Modulator stream
    output logic density_stream_out = 1'b0
);
    // ----------------------------------------
    // Clock dividers and framing
    // ----------------------------------------
    // Whole half periods of 24 and 25 cycles are the closest to the nominal
    // rate; the unequal counts keep the two main clocks drifting apart
    int enc_div = 0;
    int dec_div = 0;
    int tick = 0;

    // Updated on the edge itself so the bench never reads them mid-change
    always @(posedge clk_in)
    begin
        enc_div <= (enc_div == 23) ? 0 : enc_div + 1;
        dec_div <= (dec_div == 24) ? 0 : dec_div + 1;
        if (enc_div == 23)
        begin
            encoder_main_clock_out <= !encoder_main_clock_out;
            if (!encoder_main_clock_out)
                tick <= (tick + 1) % 256;
            else
            begin
                // Raised half a period early so the tick edge sees it settled
                encoder_frame_pulse_out <= (tick == 255);
                // Alternate ones: exactly half density, a zero level signal
                density_stream_out <= !density_stream_out;
            end
        end
        if (dec_div == 24)
            decoder_main_clock_out <= !decoder_main_clock_out;
    end
endmodule // codec_far_side
`default_nettype wire

// ---- sim/tb.sv ----
// Self-checking bench for the code converter
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end

module tb;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic timing_sel = 1'b0;
    logic adi_sel = 1'b0;
    logic law_sel = 1'b0;
    logic enc_sc = 1'b0;
    logic dec_sc = 1'b0;
    logic dec_fp = 1'b0;
    logic ser_in = 1'b1;
    logic sig_in = 1'b0;
    logic mod_rst = 1'b0;
    logic [1:0] dly_sel = 2'b00;
    logic dclk_seen = 1'b0;
    wire logic enc_clk, dec_clk, enc_fp, pd_in, ser_out, shape, sign, sig_out, pd_out;
    int failures = 0;
    int n_checks = 0;
    int dticks = 0;

    pcm_delta_sigma_code_converter i_pcm_delta_sigma_code_converter
    (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .interface_timing_select_in(timing_sel), .digit_inversion_select_in(adi_sel),
        .law_select_in(law_sel), .decoder_delay_sel_msb_in(dly_sel[1]),
        .decoder_delay_sel_lsb_in(dly_sel[0]), .encoder_main_clock_in(enc_clk),
        .encoder_shift_clock_in(enc_sc), .encoder_frame_pulse_in(enc_fp),
        .pulse_density_in(pd_in), .signalling_in(sig_in), .serial_code_out(ser_out),
        .noise_shaping_out(shape), .sign_bit_out(sign), .decoder_main_clock_in(dec_clk),
        .decoder_shift_clock_in(dec_sc), .decoder_frame_pulse_in(dec_fp),
        .serial_code_in(ser_in), .modulator_test_reset_in(mod_rst),
        .signalling_out(sig_out), .pulse_density_out(pd_out)
    );

    codec_far_side i_codec_far_side
    (
        .clk_in(clk_in), .encoder_main_clock_out(enc_clk), .decoder_main_clock_out(dec_clk),
        .encoder_frame_pulse_out(enc_fp), .density_stream_out(pd_in)
    );

    initial
    begin
        forever #5 clk_in = ~clk_in;
    end

    // Decoder tick count since reset, to place internal-mode bits in their slots
    always @(posedge clk_in)
    begin
        dclk_seen <= sys_rst_in ? 1'b0 : dec_clk;
        if (sys_rst_in)
            dticks <= 0;
        else if (dec_clk && !dclk_seen)
            dticks <= (dticks + 1) % 256;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic end_sim;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Inputs change and outputs are read 1 ns after the edge, once updates landed
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    function automatic logic pick(input int w);
        return (w == 0) ? enc_clk : (w == 1) ? dec_clk : enc_fp;
    endfunction

    task automatic wait_rise(input int w, input int lim);
        logic prev;
        int k;
        prev = pick(w);
        for (k = 0; k < lim; k++)
        begin
            step(1);
            if (pick(w) === 1'b1 && prev === 1'b0)
                return;
            prev = pick(w);
        end
        failures++;
        $display("BAD wait %0d exp rise got none", w);
        end_sim();
    endtask

    task automatic ticks(input int n);
        repeat (n) wait_rise(0, 100);
    endtask

    task automatic enc_int_check(input logic [7:0] w);
        int i;
        wait_rise(2, 14000);
        wait_rise(0, 100);
        for (i = 0; i < 8; i++)
        begin
            ticks(i == 0 ? 16 : 32);
            `CHK("serial bit", w[7 - i], ser_out)
            if (i == 2) `CHK("shaping high", 1'b1, shape)
            if (i == 6) `CHK("shaping low", 1'b0, shape)
        end
        `CHK("sign", 1'b1, sign)
    endtask

    // Shift clock of 50 cycles, 2 MHz, inside the allowed range
    task automatic enc_ext_check(input logic [7:0] w);
        int i;
        wait_rise(2, 14000);
        wait_rise(0, 100);
        step(4);
        for (i = 0; i < 10; i++)
        begin
            sig_in = (i == 8);
            enc_sc = 1'b1;
            step(2);
            `CHK("ext serial", (i < 8) ? w[7 - i] : (i == 8), ser_out)
            step(23);
            enc_sc = 1'b0;
            step(25);
        end
        `CHK("ext sign", w[7], sign)
    endtask

    task automatic dec_send(input logic [7:0] w);
        int i;
        for (i = 0; i < 8; i++)
        begin
            ser_in = w[7 - i];
            dec_fp = (i == 7);
            step(12);
            dec_sc = 1'b1;
            step(2);
            `CHK("signalling out", w[7 - i], sig_out)
            step(23);
            dec_sc = 1'b0;
            step(13);
        end
        dec_fp = 1'b0;
        ser_in = ~ser_in;
    endtask

    // Ones over 128 decoder ticks after the new sample settles
    task automatic dens(output int n);
        n = 0;
        step(400);
        repeat (128)
        begin
            wait_rise(1, 100);
            step(2);
            if (pd_out === 1'b1)
                n++;
        end
    endtask

    // Internal timing has no strobe to follow, so the tick count is polled
    task automatic dwait(input int t);
        int k;
        for (k = 0; k < 14000; k++)
        begin
            if (dticks == t)
                return;
            step(1);
        end
        failures++;
        $display("BAD dwait exp %0d got timeout", t);
        end_sim();
    endtask

    // One bit per 32-tick digit slot, shifted by d slots; idle line is high
    task automatic dec_int_send(input logic [7:0] w, input int d);
        int j;
        dwait(32 * d % 256);
        for (j = 0; j < 8; j++)
        begin
            ser_in = w[7 - j];
            dwait(32 * (d + j + 1) % 256);
        end
        ser_in = 1'b1;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        int n;
        step(6);
        sys_rst_in = 1'b0;
        fork
            begin
                wait_rise(2, 14000);
                enc_ext_check(8'h80);
            end
            begin
                dec_send(8'hFF);
                dens(n);
                `CHK("density high", 1'b1, n > 88)
                dec_send(8'h7F);
                dens(n);
                `CHK("density low", 1'b1, n < 40)
            end
        join
        $display("test external timing done");
        timing_sel = 1'b1;
        law_sel = 1'b1;
        adi_sel = 1'b1;
        enc_int_check(8'hAA);
        $display("test internal timing done");
        timing_sel = 1'b0;
        law_sel = 1'b0;
        dec_send(8'hAA);
        dens(n);
        `CHK("inverted density", 1'b1, n > 88)
        mod_rst = 1'b1;
        step(150);
        repeat (4)
        begin
            wait_rise(1, 100);
            step(2);
            `CHK("modulator reset", 1'b0, pd_out)
        end
        mod_rst = 1'b0;
        $display("test decoder inversion done");
        // A slot off either way turns the word positive, so density rises
        timing_sel = 1'b1;
        adi_sel = 1'b0;
        dly_sel = 2'b10;
        ser_in = 1'b1;
        dec_int_send(8'h7F, 2);
        dens(n);
        `CHK("internal delayed density", 1'b1, n < 40)
        $display("test decoder internal timing done");
        end_sim();
    end
endmodule // tb
`default_nettype wire
